//--- usb_err_consts.vh
/*
 error flag, enable and transaction status register map and field layout.
 assumes inclusion by the design file of this block and by its bench.
*/
`ifndef USB_ERR_CONSTS_VH
`define USB_ERR_CONSTS_VH

`define OFS_ERR_FLAGS     12'h000
`define OFS_ERR_ENABLES   12'h004
`define OFS_TRN_STATUS    12'h008
`define OFS_ERR_CTRL      12'h00c

`define BIT_STUFF_POS     3'd7
`define BUS_MATRIX_POS    3'd6
`define MEM_ACCESS_POS    3'd5
`define TURNAROUND_POS    3'd4
`define PARTIAL_BYTE_POS  3'd3
`define DATA_CRC_POS      3'd2
`define SHARED_BIT1_POS   3'd1
`define PACKET_ID_POS     3'd0

`define ENDPOINT_MSB      7
`define ENDPOINT_LSB      4
`define DIR_POS           3
`define BANK_POS          2

`define CTRL_HOST_POS     0
`define CTRL_SUMEN_POS    1
`define CTRL_TRN_POS      2
`define CTRL_OVF_POS      3

`define ERR_FLAGS_RESET   8'h00
`define ERR_EN_RESET      8'h00
`define CTRL_RESET        2'h0

`define FIFO_DEPTH        4
`define FIFO_PTR_W        2
`define FIFO_CNT_W        3
`define FIFO_FULL_COUNT   3'd4
`define FIFO_ONE_COUNT    3'd1

`endif

//--- usb_error_flags_status_fifo.v
/*
 usb error flags, per-flag enables, error summary and the transaction
 status fifo window, reached over apb.
 assumes the usb engine drives one-cycle event pulses synchronous to pclk.
*/
`include "usb_err_consts.vh"

module usb_error_flags_status_fifo (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // error events from the usb engine, one-cycle pulses
  input  wire        bit_stuff_evt,
  input  wire        bus_matrix_evt,
  input  wire        mem_access_evt,
  input  wire        turnaround_evt,
  input  wire        partial_byte_evt,
  input  wire        data_crc_evt,
  input  wire        token_crc_evt,
  input  wire        frame_end_evt,
  input  wire        packet_id_evt,
  // transaction completion from the usb engine
  input  wire        token_done,
  input  wire [3:0]  done_endpoint,
  input  wire        done_transmit,
  input  wire        done_odd_bank,
  // outputs to the surrounding engine
  output reg         data_packet_reject,
  output reg         token_complete_flag,
  output reg         error_summary_flag,
  output reg         module_interrupt_out,
  output reg         host_mode_select,
  output reg         fifo_overflow
);

  reg  [7:0]  err_flags_reg;
  reg  [7:0]  err_flags_next;
  reg  [7:0]  err_en_reg;
  reg         sum_en_reg;
  reg  [5:0]  fifo_mem [0:`FIFO_DEPTH-1];
  reg  [`FIFO_PTR_W-1:0] rd_ptr_reg;
  reg  [`FIFO_PTR_W-1:0] wr_ptr_reg;
  reg  [`FIFO_CNT_W-1:0] count_reg;
  reg  [7:0]  evt;
  reg  [31:0] rdata_next;
  integer     i;

  wire setup     = psel & ~penable;
  wire wr_take   = psel & penable & pwrite;
  // full compares against a count sized like the counter, not a bare integer
  wire fifo_full = (count_reg == `FIFO_FULL_COUNT);
  wire fifo_empty = (count_reg == {`FIFO_CNT_W{1'b0}});

  function sel_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      sel_hit = (a == ofs);
    end
  endfunction

  wire hit_flags = sel_hit(paddr, `OFS_ERR_FLAGS);
  wire hit_en    = sel_hit(paddr, `OFS_ERR_ENABLES);
  wire hit_stat  = sel_hit(paddr, `OFS_TRN_STATUS);
  wire hit_ctrl  = sel_hit(paddr, `OFS_ERR_CTRL);
  wire hit_any   = hit_flags | hit_en | hit_stat | hit_ctrl;

  // w1c of token complete, done on the access edge
  wire trn_clear = wr_take & hit_ctrl & pwdata[`CTRL_TRN_POS];
  // a pop only happens if an entry is actually there
  wire pop       = trn_clear & token_complete_flag & ~fifo_empty;
  wire push      = token_done & (~fifo_full | pop);

  // hardware event vector, bit 1 chosen by mode
  always @* begin
    evt = 8'h00;
    evt[`BIT_STUFF_POS]    = bit_stuff_evt;
    evt[`BUS_MATRIX_POS]   = bus_matrix_evt;
    evt[`MEM_ACCESS_POS]   = mem_access_evt;
    evt[`TURNAROUND_POS]   = turnaround_evt;
    evt[`PARTIAL_BYTE_POS] = partial_byte_evt;
    evt[`DATA_CRC_POS]     = data_crc_evt;
    evt[`SHARED_BIT1_POS]  = host_mode_select ? frame_end_evt : token_crc_evt;
    evt[`PACKET_ID_POS]    = packet_id_evt;
  end

  // set wins over the write-one clear
  always @* begin
    err_flags_next = err_flags_reg;
    if (wr_take && hit_flags) begin
      err_flags_next = err_flags_reg & ~pwdata[7:0];
    end
    err_flags_next = err_flags_next | evt;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flags_reg <= `ERR_FLAGS_RESET;
      err_en_reg    <= `ERR_EN_RESET;
      sum_en_reg    <= 1'b0;
      host_mode_select <= 1'b0;
    end else begin
      err_flags_reg <= err_flags_next;
      if (wr_take && hit_en) begin
        err_en_reg <= pwdata[7:0];
      end
      if (wr_take && hit_ctrl) begin
        host_mode_select <= pwdata[`CTRL_HOST_POS];
        sum_en_reg       <= pwdata[`CTRL_SUMEN_POS];
      end
    end
  end

  // summary and interrupt are registered from the next flag value, so they change on the same edge as the flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_summary_flag   <= 1'b0;
      module_interrupt_out <= 1'b0;
      data_packet_reject   <= 1'b0;
    end else begin
      error_summary_flag   <= |(err_flags_next & err_en_reg);
      module_interrupt_out <= (|(err_flags_next & err_en_reg)) & sum_en_reg;
      data_packet_reject   <= data_crc_evt;
    end
  end

  // status fifo; full fifo drops a new record unless a pop comes in the same cycle, and raises a sticky overflow
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_reg    <= {`FIFO_PTR_W{1'b0}};
      wr_ptr_reg    <= {`FIFO_PTR_W{1'b0}};
      count_reg     <= {`FIFO_CNT_W{1'b0}};
      fifo_overflow <= 1'b0;
      for (i = 0; i < `FIFO_DEPTH; i = i + 1) begin
        fifo_mem[i] <= 6'h00;
      end
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_reg] <= {done_endpoint, done_transmit, done_odd_bank};
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
      if (token_done && fifo_full && !pop) begin
        fifo_overflow <= 1'b1;
      end else if (wr_take && hit_ctrl && pwdata[`CTRL_OVF_POS]) begin
        fifo_overflow <= 1'b0;
      end
    end
  end

  // token complete mirrors a non-empty fifo; a pop reveals the next entry
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      token_complete_flag <= 1'b0;
    end else begin
      if (push) begin
        token_complete_flag <= 1'b1;
      end else if (pop) begin
        token_complete_flag <= (count_reg > `FIFO_ONE_COUNT);
      end else if (trn_clear) begin
        token_complete_flag <= 1'b0;
      end
    end
  end

  // read mux; status head is shown even when invalid, software checks the flag
  always @* begin
    rdata_next = 32'h0000_0000;
    if (hit_flags) begin
      rdata_next[7:0] = err_flags_reg;
    end else if (hit_en) begin
      rdata_next[7:0] = err_en_reg;
    end else if (hit_stat) begin
      rdata_next[`ENDPOINT_MSB:`ENDPOINT_LSB] = fifo_mem[rd_ptr_reg][5:2];
      rdata_next[`DIR_POS]  = fifo_mem[rd_ptr_reg][1];
      rdata_next[`BANK_POS] = fifo_mem[rd_ptr_reg][0];
    end else if (hit_ctrl) begin
      rdata_next[`CTRL_HOST_POS]  = host_mode_select;
      rdata_next[`CTRL_SUMEN_POS] = sum_en_reg;
      rdata_next[`CTRL_TRN_POS]   = token_complete_flag;
      rdata_next[`CTRL_OVF_POS]   = fifo_overflow;
    end
  end

  // no wait state: setup edge loads pready and data, access completes next edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      if (setup && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

endmodule // usb_error_flags_status_fifo

//--- usb_engine_model.sv
/* engine-side model: one-cycle error pulses and token records.
   assumes the bench calls its tasks from one process. */
module usb_engine_model (
  // clock
  input  wire logic       pclk,
  // toward the block
  output logic      [8:0] evt,
  output logic            done,
  output logic      [5:0] rec
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    evt = 0;
    done = 0;
    rec = 0;
  end
  // only this side raises flags; bits 7:0 as flagged, bit 8 frame end
  task pulse(input int b);
    @(posedge pclk);
    evt[b] <= 1;
    @(posedge pclk);
    evt <= 0;
  endtask
  // released record shows its inverse so stale values cannot pass
  task finish_token(input logic [5:0] r);
    @(posedge pclk);
    done <= 1;
    rec <= r;
    @(posedge pclk);
    done <= 0;
    rec <= ~r;
  endtask
endmodule // usb_engine_model

//--- usb_err_checker_assertions.sv
/* port checker for the error flag and status fifo block.
   assumes binding to the design top; one clock domain. */
module usb_err_checker (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // engine side
  input wire logic        data_crc_evt,
  input wire logic        data_packet_reject,
  input wire logic        token_done,
  input wire logic        token_complete_flag,
  input wire logic        error_summary_flag,
  input wire logic        module_interrupt_out,
  input wire logic        host_mode_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  crc_reject_a: assert property (data_crc_evt |=> data_packet_reject)
    else $error("no reject after crc fail");
  reject_cause_a: assert property (data_packet_reject |-> $past(data_crc_evt))
    else $error("reject without crc fail");
  // irq is registered in the same stage as the summary; the check also accepts a summary one cycle earlier
  irq_gate_a: assert property (module_interrupt_out |-> error_summary_flag || $past(error_summary_flag))
    else $error("irq without summary");
  token_set_a: assert property (token_done |=> token_complete_flag)
    else $error("token flag not set");
  token_cause_a: assert property ($rose(token_complete_flag) |-> $past(token_done))
    else $error("token flag without done");
  token_pop_a: assert property ($fell(token_complete_flag) |-> $past(psel && penable && pwrite))
    else $error("token flag fell without write");
  read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 0)
    else $error("upper read bits set");
  mode_write_a: assert property ($changed(host_mode_select) |-> $past(psel && penable && pwrite))
    else $error("mode changed without write");
  cover property (data_packet_reject);
  cover property (module_interrupt_out);
  cover property ($fell(token_complete_flag));
endmodule // usb_err_checker
bind usb_error_flags_status_fifo usb_err_checker i_usb_err_checker (.*);

//--- usb_error_flags_status_fifo_test.sv
/* bench: apb tasks plus engine model drive the error flags and fifo.
   assumes the design header and the bound checker. */
`include "usb_err_consts.vh"
module usb_error_flags_status_fifo_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, done, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        pready, pslverr, dpr, tcf, esf, irq, hms, ovf;
  logic [8:0]  evt;
  logic [5:0]  rec;
  int          error_cnt, total_checks, cyc, b;
  logic [5:0]  recs [5] = '{6'h3f, 6'h00, 6'h2a, 6'h15, 6'h01};
  usb_engine_model i_usb_engine_model (.pclk(pclk), .evt(evt), .done(done), .rec(rec));
  usb_error_flags_status_fifo i_usb_error_flags_status_fifo (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .bit_stuff_evt(evt[7]), .bus_matrix_evt(evt[6]),
    .mem_access_evt(evt[5]), .turnaround_evt(evt[4]), .partial_byte_evt(evt[3]), .data_crc_evt(evt[2]),
    .token_crc_evt(evt[1]), .frame_end_evt(evt[8]), .packet_id_evt(evt[0]), .token_done(done),
    .done_endpoint(rec[5:2]), .done_transmit(rec[1]), .done_odd_bank(rec[0]), .data_packet_reject(dpr),
    .token_complete_flag(tcf), .error_summary_flag(esf), .module_interrupt_out(irq),
    .host_mode_select(hms), .fifo_overflow(ovf));
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task end_of_test;
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      end_of_test;
    end
  end
  task chk(input string n, input logic [31:0] s, x);
    total_checks++;
    if (s !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", n, x, s);
    end
  endtask
  // the slave's wait is never assumed; the loop polls pready, and only the timeout ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rd(input string n, input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(n, rv, x);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task settle;
    repeat (2) @(negedge pclk);
  endtask
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    chk("outputs", {dpr, tcf, esf, irq, hms, ovf}, 0);
    rd("flags", `OFS_ERR_FLAGS, 0);
    rd("enables", `OFS_ERR_ENABLES, 0);
    wr(`OFS_ERR_ENABLES, 32'hffffffff);
    rd("enables", `OFS_ERR_ENABLES, 32'hff);
    wr(`OFS_ERR_ENABLES, 0);
    for (b = 0; b < 8; b++) begin
      i_usb_engine_model.pulse(b);
      rd("flag", `OFS_ERR_FLAGS, 1 << b);
      chk("summary", esf, 0);
      wr(`OFS_ERR_ENABLES, 1 << b);
      settle;
      chk("summary", esf, 1);
      chk("irq", irq, 0);
      wr(`OFS_ERR_CTRL, 2);
      settle;
      chk("irq", irq, 1);
      wr(`OFS_ERR_FLAGS, ~(1 << b));
      rd("flag", `OFS_ERR_FLAGS, 1 << b);
      wr(`OFS_ERR_FLAGS, 1 << b);
      rd("flag", `OFS_ERR_FLAGS, 0);
      wr(`OFS_ERR_ENABLES, 0);
      wr(`OFS_ERR_CTRL, 0);
    end
    wr(`OFS_ERR_CTRL, 1);
    i_usb_engine_model.pulse(1);
    rd("flag", `OFS_ERR_FLAGS, 0);
    i_usb_engine_model.pulse(8);
    rd("flag", `OFS_ERR_FLAGS, 2);
    wr(`OFS_ERR_ENABLES, 2);
    settle;
    chk("summary", esf, 1);
    wr(`OFS_ERR_FLAGS, 2);
    wr(`OFS_ERR_CTRL, 0);
    wr(12'h010, 32'hff);
    chk("slverr", e, 1);
    rd("unmapped", 12'h010, 0);
    for (b = 0; b < 5; b++) i_usb_engine_model.finish_token(recs[b]);
    settle;
    chk("token", tcf, 1);
    rd("ctrl", `OFS_ERR_CTRL, 32'hc);
    for (b = 0; b < 4; b++) begin
      rd("status", `OFS_TRN_STATUS, {recs[b], 2'b00});
      wr(`OFS_ERR_CTRL, 4);
    end
    settle;
    chk("token", tcf, 0);
    wr(`OFS_ERR_CTRL, 8);
    rd("ctrl", `OFS_ERR_CTRL, 0);
    end_of_test;
  end
endmodule // usb_error_flags_status_fifo_test
